/* File: design/wwhg_top.sv */
// Window watchdog with halt-mode guard, APB register slave.
// Assumes one 40 MHz pclk; option straps are quasi-static pins.
//
// Summary of operation
// RQ1: The counter steps down once per 16384 divided oscillator cycles.
// RQ2: The counter is seven bits in control bits 6:0, timeout in 64 steps.
// RQ3: When active, a fall from 40h to 3Fh starts a reset cycle.
// RQ4: A watchdog reset holds the reset pin low for about 30 us.
// RQ5: A reload while the count exceeds the window value causes a reset.
// RQ6: Software reloads only at or below the window and before bit six clears.
// RQ7: The watchdog acts only when activated, by hardware or software option.
// RQ8: An option decides whether halt with an active watchdog resets.
// RQ9: With active halt enabled, halt with an active watchdog never resets.
// RQ10: Halt enters active halt when the osc irq enable is 1 and wakeup is 0.
// RQ11: Leaving active halt by reset waits 4096 or 256 cycles by option.
// RQ12: Entering active halt forces the interrupt mask bits to 10b.
// RQ13: In active halt only the oscillator and real-time counter run.
// RQ14: Active halt is left on the rtc interrupt, other wakeups or reset.
// RQ15: Underflow and early reload drive one shared reset request.
`timescale 1ns/1ps
module wwhg_top (
    input  wire logic        pclk,       // 40 MHz clock
    input  wire logic        presetn,    // async reset, active low
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB write
    input  wire logic [7:0]  paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic      [31:0] prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error
    input  wire logic        opt_hw_act, // strap: hardware activation
    input  wire logic        opt_halt_rst, // strap: reset on halt
    input  wire logic        opt_short,  // strap: 256-cycle restart
    input  wire logic        rtc_irq,    // rtc wakeup interrupt (pin)
    input  wire logic        ext_wake,   // other wakeup interrupt (pin)
    output logic             rst_pin_n,  // external reset, active low
    output logic             osc_run,    // oscillator/rtc clock enable
    output logic             periph_run, // peripheral clock enable
    output logic      [1:0]  imask,      // forced interrupt mask bits
    output logic             irq         // level interrupt
);
    // ========================================================
    // Input synchronisers and option capture
    // ========================================================
    logic [1:0] rtc_s_q, wake_s_q, hw_s_q, hr_s_q, sh_s_q;
    wwhg_pkg::wwhg_opt_t opt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rtc_s_q  <= 2'h0;
            wake_s_q <= 2'h0;
            hw_s_q   <= 2'h0;
            hr_s_q   <= 2'h0;
            sh_s_q   <= 2'h0;
        end
        else
        begin
            rtc_s_q  <= {rtc_s_q[0], rtc_irq};
            wake_s_q <= {wake_s_q[0], ext_wake};
            hw_s_q   <= {hw_s_q[0], opt_hw_act};
            hr_s_q   <= {hr_s_q[0], opt_halt_rst};
            sh_s_q   <= {sh_s_q[0], opt_short};
        end
    end

    // Options follow the synchronised straps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            opt_q <= '0;
        else
            opt_q <= '{hw_act: hw_s_q[1], halt_rst: hr_s_q[1],
                       short_rst: sh_s_q[1]};
    end

    // ========================================================
    // APB decode
    // ========================================================
    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire a_ctrl  = paddr == wwhg_pkg::ADDR_CTRL;
    wire a_win   = paddr == wwhg_pkg::ADDR_WINDOW;
    wire a_opt   = paddr == wwhg_pkg::ADDR_OPT;
    wire a_clk   = paddr == wwhg_pkg::ADDR_CLK;
    wire a_halt  = paddr == wwhg_pkg::ADDR_HALT;
    wire a_stat  = paddr == wwhg_pkg::ADDR_STAT;
    wire a_mask  = paddr == wwhg_pkg::ADDR_MASK;
    wire mapped  = a_ctrl | a_win | a_opt | a_clk | a_halt | a_stat | a_mask;
    wire wr_ctrl = wr && a_ctrl;
    wire wr_win  = wr && a_win;
    wire wr_clk  = wr && a_clk;
    wire wr_halt = wr && a_halt;
    wire wr_stat = wr && a_stat;
    wire wr_mask = wr && a_mask;

    // ========================================================
    // Registers
    // ========================================================
    logic [6:0] cnt_q, win_q;
    logic       act_q, oie_q, awu_q;
    logic [wwhg_pkg::NUM_EVT-1:0] stat_q, mask_q, evt;
    wwhg_pkg::wwhg_pwr_t pwr_q;

    wire act     = act_q | opt_q.hw_act;                          // [RQ7]
    wire in_halt = (pwr_q == wwhg_pkg::WWHG_HALT) ||
                   (pwr_q == wwhg_pkg::WWHG_ACT_HALT);

    // ========================================================
    // Time base: pclk -> divided osc -> counter step
    // ========================================================
    wire osc_tick;
    wire step;

    // Divided oscillator clock; stops in plain halt only
    wwhg_div #(.DIV(wwhg_pkg::OSC_DIV)) u_osc_div (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (1'b0),
        .en      (pwr_q != wwhg_pkg::WWHG_HALT),                  // [RQ13]
        .tick    (osc_tick)
    );

    // One counter step per 16384 divided osc cycles, frozen in halt
    wwhg_div #(.DIV(wwhg_pkg::TICK_OSC)) u_step_div (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (wr_ctrl),
        .en      (osc_tick && !in_halt),                         // [RQ1]
        .tick    (step)
    );

    // ========================================================
    // Fault detection
    // ========================================================
    wire [6:0] cnt_dec  = cnt_q - 7'h01;
    wire under   = act && step && cnt_q[wwhg_pkg::CNT_TOP_POS] &&
                   !cnt_dec[wwhg_pkg::CNT_TOP_POS];               // [RQ3]
    wire early   = act && wr_ctrl && (cnt_q > win_q);             // [RQ5]
    wire halt_go = wr_halt && pwdata[wwhg_pkg::HALT_CMD_POS] && !in_halt;
    wire to_act  = oie_q && !awu_q;                               // [RQ10]
    wire halt_rs = halt_go && act && opt_q.halt_rst && !to_act;   // [RQ8] [RQ9]
    wire wd_rst  = under | early | halt_rs;                       // [RQ15]

    // ========================================================
    // Reset pulse and restart delay
    // ========================================================
    wire        pulse_busy, pulse_done, rs_busy, rs_done;
    wire [12:0] rs_len = opt_q.short_rst ?
                         13'(wwhg_pkg::RESTART_SHORT) :
                         13'(wwhg_pkg::RESTART_LONG);             // [RQ11]
    wire        rtc_w  = rtc_s_q[1];
    wire        ext_w  = wake_s_q[1];
    wire        sw_w   = wr_halt && pwdata[wwhg_pkg::HALT_WAKE_POS];
    wire        wake   = in_halt && (wd_rst || sw_w || ext_w ||
                         (rtc_w && pwr_q == wwhg_pkg::WWHG_ACT_HALT)); // [RQ14]

    // Reset pin low for the fixed pulse length
    wwhg_delay #(.W(11)) u_pulse (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (wd_rst && !pulse_busy),                         // [RQ4]
        .len     (11'(wwhg_pkg::RST_PULSE_CYC - 1)),              // Start adds one
        .busy    (pulse_busy),
        .done    (pulse_done)
    );

    // Oscillator restart delay before the core resumes
    wwhg_delay #(.W(13)) u_restart (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (wake),                                          // [RQ11]
        .len     (rs_len),
        .busy    (rs_busy),
        .done    (rs_done)
    );

    // ========================================================
    // Power state machine
    // ========================================================
    wwhg_pkg::wwhg_pwr_t pwr_d;

    always_comb
    begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            wwhg_pkg::WWHG_RUN:
                if (halt_go && !halt_rs)
                    pwr_d = to_act ? wwhg_pkg::WWHG_ACT_HALT
                                   : wwhg_pkg::WWHG_HALT;         // [RQ10]
            wwhg_pkg::WWHG_HALT,
            wwhg_pkg::WWHG_ACT_HALT:
                if (wake)
                    pwr_d = wwhg_pkg::WWHG_RESTART;
            wwhg_pkg::WWHG_RESTART:
                if (rs_done)
                    pwr_d = wwhg_pkg::WWHG_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwr_q <= wwhg_pkg::WWHG_RUN;
        else
            pwr_q <= pwr_d;
    end

    // ========================================================
    // Watchdog counter and control registers
    // ========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= wwhg_pkg::CNT_RST;
            act_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            cnt_q <= pwdata[6:0];                                 // [RQ2]
            act_q <= act_q | pwdata[wwhg_pkg::CTRL_ACT_POS];      // [RQ7]
        end
        else if (step)
            cnt_q <= cnt_dec;                                     // [RQ1]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            win_q  <= wwhg_pkg::WIN_RST;
            oie_q  <= 1'b0;
            awu_q  <= 1'b0;
            mask_q <= '0;
        end
        else
        begin
            if (wr_win)
                win_q <= pwdata[6:0];
            if (wr_clk)
            begin
                oie_q <= pwdata[wwhg_pkg::CLK_OIE_POS];
                awu_q <= pwdata[wwhg_pkg::CLK_AWU_POS];
            end
            if (wr_mask)
                mask_q <= pwdata[wwhg_pkg::NUM_EVT-1:0];
        end
    end

    // ========================================================
    // Sticky status, set wins over write-one clear
    // ========================================================
    always_comb
    begin
        evt = '0;
        evt[wwhg_pkg::EVT_UNDER] = under;
        evt[wwhg_pkg::EVT_EARLY] = early;
        evt[wwhg_pkg::EVT_HALT]  = halt_rs;
        evt[wwhg_pkg::EVT_WAKE]  = rs_done;
    end

    wire [wwhg_pkg::NUM_EVT-1:0] clr = wr_stat ?
                                       pwdata[wwhg_pkg::NUM_EVT-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_q <= '0;
        else
            stat_q <= (stat_q & ~clr) | evt;
    end

    // ========================================================
    // Read mux and outputs
    // ========================================================
    wire [31:0] rd_ctrl = {24'h0, act, cnt_q};
    wire [31:0] rd_opt  = {29'h0, opt_q.short_rst, opt_q.halt_rst,
                           opt_q.hw_act};
    wire [31:0] rd_mux  =
        a_ctrl ? rd_ctrl :
        a_win  ? {25'h0, win_q} :
        a_opt  ? rd_opt :
        a_clk  ? {30'h0, awu_q, oie_q} :
        a_halt ? {30'h0, pwr_q} :
        a_stat ? {28'h0, stat_q} :
        a_mask ? {28'h0, mask_q} : 32'h0;

    wwhg_pkg::wwhg_clkst_t clk_d;
    assign clk_d.run    = pwr_d != wwhg_pkg::WWHG_HALT;            // [RQ13]
    assign clk_d.periph = pwr_d == wwhg_pkg::WWHG_RUN;             // [RQ13]
    assign clk_d.imask  = wwhg_pkg::IMASK_HALT;                    // [RQ12]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata     <= 32'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            rst_pin_n  <= 1'b1;
            osc_run    <= 1'b1;
            periph_run <= 1'b1;
            imask      <= 2'h0;
            irq        <= 1'b0;
        end
        else
        begin
            pready     <= psel && !penable;
            pslverr    <= psel && !penable && !mapped;
            prdata     <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
            rst_pin_n  <= !(pulse_busy || (wd_rst && !pulse_busy)); // [RQ4]
            osc_run    <= clk_d.run;
            periph_run <= clk_d.periph;
            if (halt_go)
                imask <= clk_d.imask;                             // [RQ12]
            irq        <= |(stat_q & mask_q);
        end
    end

    wire unused_ok = pulse_done;
endmodule

/* File: design/wwhg_pkg.sv */
// Package for the window watchdog with halt guard.
// Assumes one 40 MHz clock (pclk) and an APB register slave.
package wwhg_pkg;

    // ========================================================
    // Register map (byte addresses)
    // ========================================================
    localparam logic [7:0] ADDR_CTRL   = 8'h00; // watchdog_control_reg
    localparam logic [7:0] ADDR_WINDOW = 8'h04; // window value
    localparam logic [7:0] ADDR_OPT    = 8'h08; // option settings
    localparam logic [7:0] ADDR_CLK    = 8'h0C; // clock/wakeup enables
    localparam logic [7:0] ADDR_HALT   = 8'h10; // halt command / state
    localparam logic [7:0] ADDR_STAT   = 8'h14; // sticky events
    localparam logic [7:0] ADDR_MASK   = 8'h18; // interrupt mask

    // ========================================================
    // Field positions
    // ========================================================
    localparam int CTRL_ACT_POS   = 7;  // wd_activate_bit
    localparam int CNT_TOP_POS    = 6;  // wd_count_top_bit
    localparam int OPT_HWACT_POS  = 0;  // hardware activation
    localparam int OPT_HALTRST_POS = 1; // reset on halt
    localparam int OPT_SHORT_POS  = 2;  // 256-cycle restart
    localparam int CLK_OIE_POS    = 0;  // osc_irq_enable_bit
    localparam int CLK_AWU_POS    = 1;  // auto_wakeup_enable_bit
    localparam int HALT_CMD_POS   = 0;  // write 1: halt instruction
    localparam int HALT_WAKE_POS  = 1;  // write 1: wake request

    localparam int NUM_EVT = 4;
    localparam int EVT_UNDER = 0;  // counter underflow
    localparam int EVT_EARLY = 1;  // early reload
    localparam int EVT_HALT  = 2;  // halt reset
    localparam int EVT_WAKE  = 3;  // restart delay done

    // ========================================================
    // Reset values and forced halt mask
    // ========================================================
    localparam logic [6:0] CNT_RST    = 7'h7F;
    localparam logic [6:0] WIN_RST    = 7'h7F;
    localparam logic [1:0] IMASK_HALT = 2'h2; // forced mask bits 10b

    // ========================================================
    // Timing
    // ========================================================
    localparam int CLK_MHZ       = 40;
    localparam int OSC_DIV       = 5;     // pclk / divided_osc_clock
    localparam int TICK_OSC      = 16384; // osc cycles per decrement
    localparam int RST_PULSE_US  = 30;
    localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_MHZ;
    localparam int RESTART_LONG  = 4096;
    localparam int RESTART_SHORT = 256;

    // ========================================================
    // Types
    // ========================================================
    typedef enum logic [1:0] {
        WWHG_RUN,
        WWHG_HALT,
        WWHG_ACT_HALT,
        WWHG_RESTART
    } wwhg_pwr_t;

    typedef struct packed {
        logic hw_act;    // force activation
        logic halt_rst;  // reset on halt allowed
        logic short_rst; // 256-cycle restart delay
    } wwhg_opt_t;

    typedef struct packed {
        logic       run;   // oscillator / rtc running
        logic       periph; // other peripherals clocked
        logic [1:0] imask; // condition_code_reg mask bits
    } wwhg_clkst_t;

endpackage

/* File: design/wwhg_div.sv */
// Divider producing a one-cycle enable every DIV input enables.
// Assumes en is a same-domain enable, either a held level or a one-cycle strobe.
`timescale 1ns/1ps
module wwhg_div #(
    parameter int DIV = 2
) (
    input  wire logic pclk,    // system clock
    input  wire logic presetn, // async reset, active low
    input  wire logic clr,     // restart the count
    input  wire logic en,      // input enable
    output logic      tick     // one-cycle output enable
);
    localparam int W = $clog2(DIV + 1);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_q;
    wire          wrap = en && (cnt_q == LAST);

    // Counter with wrap pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            tick <= wrap && !clr;
            if (clr || wrap)
                cnt_q <= '0;
            else if (en)
                cnt_q <= cnt_q + W'(1);
        end
    end
endmodule

/* File: design/wwhg_delay.sv */
// Down-counting timer loaded with a length, pulses done at zero.
// Assumes start is a one-cycle strobe on pclk.
`timescale 1ns/1ps
module wwhg_delay #(
    parameter int W = 13
) (
    input  wire logic         pclk,    // system clock
    input  wire logic         presetn, // async reset, active low
    input  wire logic         start,   // load and run
    input  wire logic [W-1:0] len,     // length in cycles
    output logic              busy,    // counting
    output logic              done     // one-cycle end pulse
);
    logic [W-1:0] cnt_q;

    // Load, count down, flag end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                cnt_q <= len;
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                cnt_q <= cnt_q - W'(1);
                if (cnt_q == W'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: testbench/wwhg_props.sv */
// Port checker for the watchdog top level.
// Assumes binding to wwhg_top; straps change only while idle.
`timescale 1ns/1ps
module wwhg_props (
    input wire logic        pclk,         // clock
    input wire logic        presetn,      // reset
    input wire logic        psel,         // apb
    input wire logic        penable,      // apb
    input wire logic        pwrite,       // apb
    input wire logic [7:0]  paddr,        // apb
    input wire logic [31:0] pwdata,       // apb
    input wire logic [31:0] prdata,       // apb
    input wire logic        pready,       // apb
    input wire logic        pslverr,      // apb
    input wire logic        opt_hw_act,   // strap
    input wire logic        rst_pin_n,    // reset pin
    input wire logic        osc_run,      // osc enable
    input wire logic        periph_run,   // periph enable
    input wire logic [1:0]  imask,        // mask bits
    input wire logic        irq           // interrupt
);
    localparam int STEP = wwhg_pkg::OSC_DIV * (wwhg_pkg::TICK_OSC - 1);
    logic [11:0] lo_cnt_q;
    logic [16:0] age_q;
    logic [6:0]  win_q, cnt_q;
    logic [3:0]  mask_q;
    wire         wr_done = psel && penable && pready && pwrite;
    wire         ctrl_wr = wr_done && paddr == wwhg_pkg::ADDR_CTRL;

    // ========================================================
    // Mirrors of low time, count and its age, window, mask
    // ========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lo_cnt_q <= 12'h000;
            age_q    <= 17'h1FFFF;
            cnt_q    <= wwhg_pkg::CNT_RST;
            win_q    <= wwhg_pkg::WIN_RST;
            mask_q   <= 4'h0;
        end
        else
        begin
            lo_cnt_q <= rst_pin_n ? 12'h000 : lo_cnt_q + 12'h001;
            age_q    <= ctrl_wr ? 17'h00000 : age_q + {16'h0000, ~&age_q};
            if (ctrl_wr)
                cnt_q <= pwdata[6:0];
            if (wr_done && paddr == wwhg_pkg::ADDR_WINDOW)
                win_q <= pwdata[6:0];
            if (wr_done && paddr == wwhg_pkg::ADDR_MASK)
                mask_q <= pwdata[3:0];
        end
    end

    // ========================================================
    // Assertions
    // ========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_after_setup_a:
        assert property (psel && !penable |=> pready)
        else $error("no ready");
    ready_single_a:
        assert property (pready |=> !pready)
        else $error("ready too long");
    err_reads_zero_a:
        assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
    pulse_length_a:
        assert property ($rose(rst_pin_n) |->
            lo_cnt_q == wwhg_pkg::RST_PULSE_CYC)
        else $error("bad pulse length");
    early_reload_a:
        assert property (ctrl_wr && opt_hw_act && age_q < STEP &&
            cnt_q > win_q && rst_pin_n |-> ##[1:3] !rst_pin_n)
        else $error("early reload no reset");
    halt_mask_a:
        assert property ($fell(periph_run) |-> ##[0:1] imask == 2'h2)
        else $error("mask not forced");
    osc_stop_a:
        assert property (!osc_run |-> !periph_run)
        else $error("periph without osc");
    masked_irq_a:
        assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0
            |-> !irq)
        else $error("masked irq");
endmodule

bind wwhg_top wwhg_props u_props (.*);

/* File: testbench/wwhg_top_tb.sv */
// Self-checking bench for the watchdog with halt guard.
// Assumes zero-wait APB slave and a 40 MHz pclk.
`timescale 1ns/1ps
module wwhg_top_tb;
    logic pclk, presetn, psel, penable, pwrite, se;
    logic opt_hw_act, opt_halt_rst, opt_short, rtc_irq, ext_wake;
    logic pready, pslverr, rst_pin_n, osc_run, periph_run, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  imask;
    int          err_total, comparisons, cyc, n;

    wwhg_top dut (.*);

    // ========================================================
    // Clock, cycle limit and helpers
    // ========================================================
    always #12.5 pclk = ~pclk;

    // Cuts a hang short
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 100000)
        begin
            err_total++;
            tally_and_finish;
        end
    end

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; holds until pready is sampled high
    task apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Counts edges until: 0 reset low, 1 peripherals run, 2 reset high
    task wait_for(input int which, input int lim);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (n < lim && !(which == 0 ? rst_pin_n === 1'b0 :
            which == 1 ? periph_run === 1'b1 : rst_pin_n === 1'b1));
    endtask

    // Fault seen on the pin, then its low time
    task fault_pulse;
        wait_for(0, 40);
        chk({31'h0, rst_pin_n}, 32'h0);
        wait_for(2, 1300);
        chk(n, wwhg_pkg::RST_PULSE_CYC);
    endtask

    // ========================================================
    // Main sequence
    // ========================================================
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {opt_hw_act, opt_halt_rst, opt_short, rtc_irq, ext_wake} = '0;
        cyc = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Defaults, unmapped access, inactive early reload
        rdchk(wwhg_pkg::ADDR_CTRL, 32'h0000007F);
        rdchk(wwhg_pkg::ADDR_WINDOW, 32'h0000007F);
        rdchk(wwhg_pkg::ADDR_OPT, 32'h00000000);
        apb(1'b1, 8'h1C, 32'h000000FF);
        chk({31'h0, se}, 32'h1);
        rdchk(8'h1C, 32'h0);
        apb(1'b1, wwhg_pkg::ADDR_MASK, 32'h0000000F);
        rdchk(wwhg_pkg::ADDR_MASK, 32'h0000000F);
        apb(1'b1, wwhg_pkg::ADDR_WINDOW, 32'h00000050);
        apb(1'b1, wwhg_pkg::ADDR_CTRL, 32'h00000050);
        repeat (20) @(posedge pclk);
        chk({31'h0, rst_pin_n}, 32'h1);
        rdchk(wwhg_pkg::ADDR_STAT, 32'h0);
        $display("test defaults done");
        // Hardware activation, window edge, early reload, interrupt
        opt_hw_act <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(wwhg_pkg::ADDR_CTRL, 32'h000000D0);
        apb(1'b1, wwhg_pkg::ADDR_CTRL, 32'h0000007F);
        repeat (20) @(posedge pclk);
        chk({31'h0, rst_pin_n}, 32'h1);
        apb(1'b1, wwhg_pkg::ADDR_MASK, 32'h0);
        apb(1'b1, wwhg_pkg::ADDR_CTRL, 32'h00000051);
        fault_pulse;
        rdchk(wwhg_pkg::ADDR_STAT, 32'h00000002);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, wwhg_pkg::ADDR_MASK, 32'h00000002);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, wwhg_pkg::ADDR_STAT, 32'h00000002);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        $display("test early reload done");
        // Halt while active with reset option, plain halt variant
        opt_halt_rst <= 1'b1;
        apb(1'b1, wwhg_pkg::ADDR_CLK, 32'h0);
        repeat (4) @(posedge pclk);
        apb(1'b1, wwhg_pkg::ADDR_HALT, 32'h00000001);
        fault_pulse;
        rdchk(wwhg_pkg::ADDR_STAT, 32'h00000004);
        rdchk(wwhg_pkg::ADDR_HALT, 32'h0);
        apb(1'b1, wwhg_pkg::ADDR_STAT, 32'h0000000F);
        // Active halt: no reset, mask forced, rtc wake, long restart
        apb(1'b1, wwhg_pkg::ADDR_CLK, 32'h00000001);
        apb(1'b1, wwhg_pkg::ADDR_HALT, 32'h00000001);
        repeat (4) @(posedge pclk);
        rdchk(wwhg_pkg::ADDR_HALT, 32'h00000002);
        chk({31'h0, rst_pin_n}, 32'h1);
        chk({30'h0, imask}, 32'h2);
        chk({30'h0, osc_run, periph_run}, 32'h2);
        rtc_irq <= 1'b1;
        wait_for(1, 5000);
        chk(n >= 4096 && n <= 4110, 32'h1);
        rtc_irq <= 1'b0;
        rdchk(wwhg_pkg::ADDR_STAT, 32'h00000008);
        $display("test active halt done");
        // Plain halt with wakeup enabled, ext wake, short restart
        opt_halt_rst <= 1'b0;
        opt_short <= 1'b1;
        apb(1'b1, wwhg_pkg::ADDR_CLK, 32'h00000003);
        repeat (4) @(posedge pclk);
        apb(1'b1, wwhg_pkg::ADDR_HALT, 32'h00000001);
        repeat (4) @(posedge pclk);
        rdchk(wwhg_pkg::ADDR_HALT, 32'h00000001);
        chk({30'h0, osc_run, periph_run}, 32'h0);
        rtc_irq <= 1'b1;
        repeat (10) @(posedge pclk);
        rdchk(wwhg_pkg::ADDR_HALT, 32'h00000001);
        rtc_irq <= 1'b0;
        ext_wake <= 1'b1;
        wait_for(1, 400);
        chk(n >= 256 && n <= 270, 32'h1);
        ext_wake <= 1'b0;
        $display("test plain halt done");
        // Underflow from 40h after one full step, reset mid-pulse
        apb(1'b1, wwhg_pkg::ADDR_STAT, 32'h0000000F);
        apb(1'b1, wwhg_pkg::ADDR_WINDOW, 32'h0000007F);
        apb(1'b1, wwhg_pkg::ADDR_CTRL, 32'h00000040);
        wait_for(0, 84000);
        chk(n >= 81915 && n <= 81930, 32'h1);
        rdchk(wwhg_pkg::ADDR_STAT, 32'h00000001);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, rst_pin_n}, 32'h1);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(wwhg_pkg::ADDR_CTRL, 32'h000000FF);
        $display("test underflow done");
        tally_and_finish;
    end
endmodule
